// File: include/optical_alarm_pkg.sv
// shared constants and types for the optical power alarm threshold bank
// Functional notes
// - tx power below low threshold sets alarm
// - rx power above high threshold sets alarm
// - rx power below low threshold sets alarm
// - threshold low bytes are storage only
// - high and low bytes form unsigned sixteen bits
// - high byte count equals 25.6 microwatts
// - low byte count equals 0.1 microwatts
// - threshold bytes read/write, reset to zero
// - compare raw values, no calibration applied
// - tx power above high threshold sets alarm
package optical_alarm_pkg;

   // serial management bus slave address, seven bits
   localparam logic [6:0] DEV_ADDR         = 7'h51;

   // threshold byte offsets on the serial bus
   localparam logic [7:0] TX_HIGH_HI_OFS   = 8'h18;
   localparam logic [7:0] TX_HIGH_LO_OFS   = 8'h19;
   localparam logic [7:0] TX_LOW_HI_OFS    = 8'h1A;
   localparam logic [7:0] TX_LOW_LO_OFS    = 8'h1B;
   localparam logic [7:0] RX_HIGH_HI_OFS   = 8'h20;
   localparam logic [7:0] RX_HIGH_LO_OFS   = 8'h21;
   localparam logic [7:0] RX_LOW_HI_OFS    = 8'h22;
   localparam logic [7:0] RX_LOW_LO_OFS    = 8'h23;
   // read-only status bytes
   localparam logic [7:0] ALARM_FLAGS_OFS  = 8'h70;
   localparam logic [7:0] TX_MEAS_HI_OFS   = 8'h66;
   localparam logic [7:0] RX_MEAS_HI_OFS   = 8'h68;

   // alarm flag bit positions within the flags byte
   localparam int         TX_HIGH_BIT      = 7;
   localparam int         TX_LOW_BIT       = 6;
   localparam int         RX_HIGH_BIT      = 5;
   localparam int         RX_LOW_BIT       = 4;

   // reset value of every threshold byte (0 mW)
   localparam logic [7:0] THR_RESET        = 8'h00;
   // unmapped bytes read as this
   localparam logic [7:0] UNMAPPED_READ    = 8'h00;

   // weight of one count, in nanowatts
   localparam int         HI_LSB_NW        = 25600;
   localparam int         LO_LSB_NW        = 100;

   // one threshold: measured-against byte plus storage-only byte
   typedef struct packed {
      logic [7:0] hi;
      logic [7:0] lo;
   } threshold_t;

   // the four alarm thresholds
   typedef struct packed {
      threshold_t txHigh;
      threshold_t txLow;
      threshold_t rxHigh;
      threshold_t rxLow;
   } threshold_bank_t;

   // latched alarm flags
   typedef struct packed {
      logic txHigh;
      logic txLow;
      logic rxHigh;
      logic rxLow;
   } alarm_t;

   // one-cycle byte write from the serial engine
   typedef struct packed {
      logic       en;
      logic [7:0] addr;
      logic [7:0] data;
   } byte_write_t;

   // unsigned sixteen-bit view, high byte most significant
   function automatic logic [15:0] thrWord(input threshold_t t);
      thrWord = {t.hi, t.lo};
   endfunction

endpackage

// File: logic/optical_power_alarm_thresholds.sv
// threshold bank, alarm comparators and two-wire serial slave
`timescale 1ns/1ps
`default_nettype none
module optical_power_alarm_thresholds (
   // clock and reset
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   // two-wire serial management pins (open drain)
   input  wire logic                          sclIn,
   input  wire logic                          sdaIn,
   output logic                               sdaOut,
   output logic                               sdaOeN,
   // measured optical power from the monitor, same clock
   input  wire logic [7:0]                    txPowerMeasHi,
   input  wire logic [7:0]                    rxPowerMeasHi,
   input  wire logic                          measValid,
   // alarm flags toward the rest of the monitor
   output optical_alarm_pkg::alarm_t          alarmFlag,
   // full sixteen-bit threshold values, raw
   output optical_alarm_pkg::threshold_bank_t thresholds
);

   // serial engine states
   typedef enum logic [2:0] {
      S_IDLE, S_ADDR, S_ACK_ADDR, S_WORD, S_ACK_WORD, S_WDATA, S_READ, S_MACK
   } serial_state_t;

   // pin synchronisers: first stage only feeds second
   logic [1:0]                      sclSync;     // scl two-flop chain
   logic [1:0]                      sdaSync;     // sda two-flop chain
   logic                            sclPrev;     // last synced scl
   logic                            sdaPrev;     // last synced sda
   logic                            sclS;        // synced scl
   logic                            sdaS;        // synced sda
   logic                            sclRise;     // scl rising edge
   logic                            sclFall;     // scl falling edge
   logic                            startCond;   // sda falls with scl high
   logic                            stopCond;    // sda rises with scl high

   // serial engine state
   serial_state_t                   state;       // current state
   serial_state_t                   next_state;
   logic [3:0]                      bitCnt;      // bits shifted this byte
   logic [3:0]                      next_bitCnt;
   logic [7:0]                      shiftIn;     // received bits
   logic [7:0]                      next_shiftIn;
   logic [7:0]                      shiftOut;    // bits being sent
   logic [7:0]                      next_shiftOut;
   logic [7:0]                      ptr;         // byte address pointer
   logic [7:0]                      next_ptr;
   logic                            rdNotWr;     // direction of transfer
   logic                            next_rdNotWr;
   logic                            oeN;         // low while pulling sda
   logic                            next_oeN;
   optical_alarm_pkg::byte_write_t  wr;          // registered write pulse
   optical_alarm_pkg::byte_write_t  next_wr;

   // register bank state
   optical_alarm_pkg::threshold_bank_t thr;
   optical_alarm_pkg::threshold_bank_t next_thr;
   optical_alarm_pkg::alarm_t          alarm;
   optical_alarm_pkg::alarm_t          next_alarm;
   logic [7:0]                         measTx;   // last tx high byte seen
   logic [7:0]                         next_measTx;
   logic [7:0]                         measRx;   // last rx high byte seen
   logic [7:0]                         next_measRx;

   // read mux, used for first byte and every follow-on byte of a read
   function automatic logic [7:0] readByte(
      input logic [7:0]                         a,
      input optical_alarm_pkg::threshold_bank_t t,
      input optical_alarm_pkg::alarm_t          f,
      input logic [7:0]                         mt,
      input logic [7:0]                         mr
   );
      logic [7:0] flags;
      flags = 8'h00;
      flags[optical_alarm_pkg::TX_HIGH_BIT] = f.txHigh;
      flags[optical_alarm_pkg::TX_LOW_BIT]  = f.txLow;
      flags[optical_alarm_pkg::RX_HIGH_BIT] = f.rxHigh;
      flags[optical_alarm_pkg::RX_LOW_BIT]  = f.rxLow;
      unique case (a)
         optical_alarm_pkg::TX_HIGH_HI_OFS:  readByte = t.txHigh.hi;
         optical_alarm_pkg::TX_HIGH_LO_OFS:  readByte = t.txHigh.lo;
         optical_alarm_pkg::TX_LOW_HI_OFS:   readByte = t.txLow.hi;
         optical_alarm_pkg::TX_LOW_LO_OFS:   readByte = t.txLow.lo;
         optical_alarm_pkg::RX_HIGH_HI_OFS:  readByte = t.rxHigh.hi;
         optical_alarm_pkg::RX_HIGH_LO_OFS:  readByte = t.rxHigh.lo;
         optical_alarm_pkg::RX_LOW_HI_OFS:   readByte = t.rxLow.hi;
         optical_alarm_pkg::RX_LOW_LO_OFS:   readByte = t.rxLow.lo;
         optical_alarm_pkg::ALARM_FLAGS_OFS: readByte = flags;
         optical_alarm_pkg::TX_MEAS_HI_OFS:  readByte = mt;
         optical_alarm_pkg::RX_MEAS_HI_OFS:  readByte = mr;
         default:                            readByte = optical_alarm_pkg::UNMAPPED_READ;
      endcase
   endfunction

   // synchroniser and edge history registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sclSync <= 2'h3;   // idle bus is high
         sdaSync <= 2'h3;
         sclPrev <= 1'b1;
         sdaPrev <= 1'b1;
      end else begin
         sclSync <= {sclSync[0], sclIn};
         sdaSync <= {sdaSync[0], sdaIn};
         sclPrev <= sclSync[1];
         sdaPrev <= sdaSync[1];
      end
   end

   // bus events, only from the second synchroniser stage onward
   always_comb begin
      sclS      = sclSync[1];
      sdaS      = sdaSync[1];
      sclRise   = sclS & ~sclPrev;
      sclFall   = ~sclS & sclPrev;
      startCond = sclS & sclPrev & sdaPrev & ~sdaS;
      stopCond  = sclS & sclPrev & ~sdaPrev & sdaS;
   end

   // serial engine next state: byte pointer, ack, shift in and out
   always_comb begin
      next_state    = state;
      next_bitCnt   = bitCnt;
      next_shiftIn  = shiftIn;
      next_shiftOut = shiftOut;
      next_ptr      = ptr;
      next_rdNotWr  = rdNotWr;
      next_oeN      = oeN;
      next_wr       = '0;
      if (startCond) begin
         // start or repeated start: fresh address phase
         next_state  = S_ADDR;
         next_bitCnt = 4'h0;
         next_oeN    = 1'b1;
      end else if (stopCond) begin
         next_state = S_IDLE;
         next_oeN   = 1'b1;
      end else begin
         unique case (state)
            S_IDLE: begin
               next_oeN = 1'b1;
            end
            S_ADDR, S_WORD, S_WDATA: begin
               if (sclRise) begin
                  next_shiftIn = {shiftIn[6:0], sdaS};
                  next_bitCnt  = bitCnt + 4'h1;
               end else if (sclFall && bitCnt == 4'h8) begin
                  next_oeN = 1'b0; // ack by default
                  if (state == S_ADDR) begin
                     if (shiftIn[7:1] == optical_alarm_pkg::DEV_ADDR) begin
                        next_rdNotWr = shiftIn[0];
                        next_state   = S_ACK_ADDR;
                     end else begin
                        // not ours: stay off the bus until next start
                        next_oeN   = 1'b1;
                        next_state = S_IDLE;
                     end
                  end else if (state == S_WORD) begin
                     next_ptr   = shiftIn;
                     next_state = S_ACK_WORD;
                  end else begin
                     // every byte is taken; unmapped ones are dropped later
                     next_wr.en   = 1'b1;
                     next_wr.addr = ptr;
                     next_wr.data = shiftIn;
                     next_ptr     = ptr + 8'h01;
                     next_state   = S_ACK_WORD;
                  end
               end
            end
            S_ACK_ADDR: begin
               if (sclFall) begin
                  next_bitCnt = 4'h0;
                  if (rdNotWr) begin
                     next_shiftOut = readByte(ptr, thr, alarm, measTx, measRx);
                     next_oeN      = next_shiftOut[7];
                     next_state    = S_READ;
                  end else begin
                     next_oeN   = 1'b1;
                     next_state = S_WORD;
                  end
               end
            end
            S_ACK_WORD: begin
               if (sclFall) begin
                  next_bitCnt = 4'h0;
                  next_oeN    = 1'b1;
                  next_state  = S_WDATA;
               end
            end
            S_READ: begin
               if (sclRise) begin
                  next_bitCnt = bitCnt + 4'h1;
               end else if (sclFall) begin
                  if (bitCnt == 4'h8) begin
                     // release so the host can ack
                     next_oeN   = 1'b1;
                     next_ptr   = ptr + 8'h01;
                     next_state = S_MACK;
                  end else begin
                     next_shiftOut = {shiftOut[6:0], 1'b0};
                     next_oeN      = shiftOut[6];
                  end
               end
            end
            S_MACK: begin
               if (sclRise && sdaS) begin
                  // host nack ends the read
                  next_state = S_IDLE;
               end else if (sclFall) begin
                  next_bitCnt   = 4'h0;
                  next_shiftOut = readByte(ptr, thr, alarm, measTx, measRx);
                  next_oeN      = next_shiftOut[7];
                  next_state    = S_READ;
               end
            end
         endcase
      end
   end

   // serial engine registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state    <= S_IDLE;
         bitCnt   <= 4'h0;
         shiftIn  <= 8'h00;
         shiftOut <= 8'h00;
         ptr      <= 8'h00;
         rdNotWr  <= 1'b0;
         oeN      <= 1'b1;
         wr       <= '0;
      end else begin
         state    <= next_state;
         bitCnt   <= next_bitCnt;
         shiftIn  <= next_shiftIn;
         shiftOut <= next_shiftOut;
         ptr      <= next_ptr;
         rdNotWr  <= next_rdNotWr;
         oeN      <= next_oeN;
         wr       <= next_wr;
      end
   end

   // threshold storage and alarm compare, next values
   always_comb begin
      next_thr    = thr;
      next_alarm  = alarm;
      next_measTx = measTx;
      next_measRx = measRx;
      if (wr.en) begin
         unique case (wr.addr)
            optical_alarm_pkg::TX_HIGH_HI_OFS: next_thr.txHigh.hi = wr.data;
            optical_alarm_pkg::TX_HIGH_LO_OFS: next_thr.txHigh.lo = wr.data;
            optical_alarm_pkg::TX_LOW_HI_OFS:  next_thr.txLow.hi  = wr.data;
            optical_alarm_pkg::TX_LOW_LO_OFS:  next_thr.txLow.lo  = wr.data;
            optical_alarm_pkg::RX_HIGH_HI_OFS: next_thr.rxHigh.hi = wr.data;
            optical_alarm_pkg::RX_HIGH_LO_OFS: next_thr.rxHigh.lo = wr.data;
            optical_alarm_pkg::RX_LOW_HI_OFS:  next_thr.rxLow.hi  = wr.data;
            optical_alarm_pkg::RX_LOW_LO_OFS:  next_thr.rxLow.lo  = wr.data;
            default: ; // read-only and unmapped bytes ignore writes
         endcase
      end
      if (measValid) begin
         // high bytes only, raw against raw; low bytes never looked at
         next_measTx       = txPowerMeasHi;
         next_measRx       = rxPowerMeasHi;
         next_alarm.txHigh = txPowerMeasHi > thr.txHigh.hi;
         next_alarm.txLow  = txPowerMeasHi < thr.txLow.hi;
         next_alarm.rxHigh = rxPowerMeasHi > thr.rxHigh.hi;
         next_alarm.rxLow  = rxPowerMeasHi < thr.rxLow.hi;
      end
   end

   // threshold and alarm registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         thr    <= {8{optical_alarm_pkg::THR_RESET}};
         alarm  <= '0;
         measTx <= 8'h00;
         measRx <= 8'h00;
      end else begin
         thr    <= next_thr;
         alarm  <= next_alarm;
         measTx <= next_measTx;
         measRx <= next_measRx;
      end
   end

   // outputs: open-drain pull low only, sdaOut tied low, the rest from flops
   assign sdaOut     = 1'b0;
   assign sdaOeN     = oeN;
   assign alarmFlag  = alarm;
   assign thresholds = thr;

endmodule
`default_nettype wire

// File: bench/serial_host_model.sv
// host controller model driving the two-wire management pins
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
   // core clock paces every pin change
   input  wire logic clk,
   // resolved data pin
   input  wire logic sdaWire,
   // host side of the pins, high means released
   output logic      scl,
   output logic      sda
);
   localparam int HALF = 12; // phase length, above the 8-clock minimum

   // bus idles released
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end

   task automatic hold();
      repeat (HALF) @(posedge clk);
   endtask

   // data moves only while the clock is low, and settles before it rises
   task automatic bitIo(input logic b, output logic r);
      repeat (4) @(posedge clk);
      sda <= b;
      hold();
      scl <= 1'b1;
      hold();
      r = sdaWire; // sampled late in the high phase
      scl <= 1'b0;
   endtask

   // start, or repeated start from a low clock
   task automatic start();
      repeat (4) @(posedge clk);
      sda <= 1'b1;
      hold();
      scl <= 1'b1;
      hold();
      sda <= 1'b0;
      hold();
      scl <= 1'b0;
   endtask

   task automatic stop();
      repeat (4) @(posedge clk);
      sda <= 1'b0;
      hold();
      scl <= 1'b1;
      hold();
      sda <= 1'b1;
      hold();
   endtask

   // eight bits msb first, then the acknowledge bit
   task automatic xfer(input logic [7:0] d, input logic hAck, output logic [7:0] r,
                       output logic dAck);
      for (int i = 7; i >= 0; i--) begin
         bitIo(d[i], r[i]);
      end
      bitIo(hAck, dAck);
   endtask

   // ok is high only if every byte was acknowledged
   task automatic writeReg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d,
                           output logic ok);
      logic [7:0] r;
      logic       k0;
      logic       k1;
      logic       k2;
      start();
      xfer({dev, 1'b0}, 1'b1, r, k0);
      xfer(a, 1'b1, r, k1);
      xfer(d, 1'b1, r, k2);
      stop();
      ok = !(k0 | k1 | k2);
   endtask

   // pointer write, repeated start, one byte read, then nack
   task automatic readReg(input logic [7:0] a, output logic [7:0] d);
      logic [7:0] r;
      logic       k;
      start();
      xfer({optical_alarm_pkg::DEV_ADDR, 1'b0}, 1'b1, r, k);
      xfer(a, 1'b1, r, k);
      start();
      xfer({optical_alarm_pkg::DEV_ADDR, 1'b1}, 1'b1, r, k);
      xfer(8'hFF, 1'b1, d, k);
      stop();
   endtask
endmodule
`default_nettype wire

// File: bench/optical_alarm_assertions.sv
// port assertions for the optical power alarm threshold bank
`timescale 1ns/1ps
`default_nettype none
module optical_alarm_checker (
   // clock and reset
   input wire logic                               clk,
   input wire logic                               rst_n,
   // serial pin enable
   input wire logic                               sdaOeN,
   // measurement in, results out
   input wire logic [7:0]                         txPowerMeasHi,
   input wire logic [7:0]                         rxPowerMeasHi,
   input wire logic                               measValid,
   input wire optical_alarm_pkg::alarm_t          alarmFlag,
   input wire optical_alarm_pkg::threshold_bank_t thresholds
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // each flag follows the raw high bytes one edge after a measurement
   chk_tx_high_flag: assert property (
      measValid |=> alarmFlag.txHigh == ($past(txPowerMeasHi) > $past(thresholds.txHigh.hi)))
      else $error("tx high flag wrong");
   chk_tx_low_flag: assert property (
      measValid |=> alarmFlag.txLow == ($past(txPowerMeasHi) < $past(thresholds.txLow.hi)))
      else $error("tx low flag wrong");
   chk_rx_high_flag: assert property (
      measValid |=> alarmFlag.rxHigh == ($past(rxPowerMeasHi) > $past(thresholds.rxHigh.hi)))
      else $error("rx high flag wrong");
   chk_rx_low_flag: assert property (
      measValid |=> alarmFlag.rxLow == ($past(rxPowerMeasHi) < $past(thresholds.rxLow.hi)))
      else $error("rx low flag wrong");
   // rx high byte equal to the rx low threshold never raises the rx low flag, whatever the low byte holds
   chk_equal_quiet: assert property (
      measValid && rxPowerMeasHi == thresholds.rxLow.hi ##1 1'b1 |-> !alarmFlag.rxLow)
      else $error("equal value raised rx low flag");
   // flags are level status between measurements
   chk_flag_hold: assert property (
      !measValid |=> $stable(alarmFlag)) else $error("flags moved without a measurement");
   chk_reset_clear: assert property (
      $rose(rst_n) |-> thresholds == '0 && alarmFlag == '0) else $error("not clear after reset");
   // a threshold only changes inside an acknowledged byte
   chk_write_in_ack: assert property (
      $changed(thresholds) |-> !sdaOeN) else $error("threshold changed outside a write");

   cover property (measValid ##1 alarmFlag.txLow);
   cover property (measValid ##1 alarmFlag.txHigh && alarmFlag.rxHigh);
   cover property ($changed(thresholds));
endmodule

bind optical_power_alarm_thresholds optical_alarm_checker u_chk (
   .clk(clk), .rst_n(rst_n), .sdaOeN(sdaOeN), .txPowerMeasHi(txPowerMeasHi),
   .rxPowerMeasHi(rxPowerMeasHi), .measValid(measValid), .alarmFlag(alarmFlag),
   .thresholds(thresholds));
`default_nettype wire

// File: bench/tb_optical_power_alarm_thresholds.sv
// self-checking bench for the optical power alarm threshold bank
`timescale 1ns/1ps
`default_nettype none
module tb_optical_power_alarm_thresholds;
   // high byte from a power in nanowatts, low byte from its residue
   localparam int         HI_NW = 3276800;
   localparam int         LO_NW = 25500;
   localparam logic [7:0] HB    = 8'(HI_NW / optical_alarm_pkg::HI_LSB_NW);
   localparam logic [7:0] LB    = 8'(LO_NW / optical_alarm_pkg::LO_LSB_NW);

   logic                               clk;
   logic                               rst_n;
   logic                               scl;        // host clock pin
   logic                               hostSda;    // host side of data pin
   wire logic                          sdaWire;    // pulled-up data pin
   logic [7:0]                         txMeas;
   logic [7:0]                         rxMeas;
   logic                               measValid;
   logic                               sdaOut;
   logic                               sdaOeN;
   optical_alarm_pkg::alarm_t          alarmFlag;
   optical_alarm_pkg::threshold_bank_t thresholds;
   int                                 badCount;
   int                                 nCompared;
   int                                 cycles;

   // measurement rows: inputs and the flags they should give
   typedef struct packed {
      logic [7:0]                tx;
      logic [7:0]                rx;
      optical_alarm_pkg::alarm_t exp;
   } row_t;
   row_t rows [7] = '{'{8'h80, 8'h90, 4'h0}, '{8'h81, 8'h91, 4'hA}, '{8'h40, 8'h30, 4'h0},
                      '{8'h3F, 8'h2F, 4'h5}, '{8'h60, 8'h60, 4'h0}, '{8'hFF, 8'h00, 4'h9},
                      '{8'h00, 8'hFF, 4'h6}};
   // threshold bytes; nonzero low bytes show they stay out of the compare
   logic [7:0] wOfs [8] = '{8'h18, 8'h19, 8'h1A, 8'h1B, 8'h20, 8'h21, 8'h22, 8'h23};
   logic [7:0] wVal [8] = '{HB, LB, 8'h40, LB, 8'h90, LB, 8'h30, LB};

   // device releases to the pull-up when not driving low
   assign sdaWire = hostSda & (sdaOeN | sdaOut);

   optical_power_alarm_thresholds u_dut (
      .clk(clk), .rst_n(rst_n), .sclIn(scl), .sdaIn(sdaWire), .sdaOut(sdaOut),
      .sdaOeN(sdaOeN), .txPowerMeasHi(txMeas), .rxPowerMeasHi(rxMeas),
      .measValid(measValid), .alarmFlag(alarmFlag), .thresholds(thresholds));

   serial_host_model u_host (.clk(clk), .sdaWire(sdaWire), .scl(scl), .sda(hostSda));

   initial clk = 1'b0;
   always #2 clk = ~clk;

   // hang guard, about 1.7 times the expected run of some 36000 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         badCount++;
         summarize();
      end
   end

   task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
      nCompared++;
      if (got !== exp) begin
         badCount++;
         $display("ERROR %0t %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask

   // one-cycle measurement, flags checked once settled
   task automatic measure(input logic [7:0] t, input logic [7:0] r);
      @(posedge clk);
      txMeas    <= t;
      rxMeas    <= r;
      measValid <= 1'b1;
      @(posedge clk);
      measValid <= 1'b0;
      @(posedge clk);
      #1;
   endtask

   task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      u_host.readReg(a, d);
      check(64'(d), 64'(exp), "read byte");
   endtask

   task automatic summarize();
      $display("compared %0d mismatches %0d", nCompared, badCount);
      if (badCount == 0 && nCompared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      logic        ok;
      logic [63:0] expBank;
      logic [7:0]  rd;
      logic        k;
      rst_n     = 1'b0;
      txMeas    = 8'h00;
      rxMeas    = 8'h00;
      measValid = 1'b0;
      badCount  = 0;
      nCompared = 0;
      cycles    = 0;
      expBank   = 64'h0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      check(64'(thresholds), 64'h0, "reset bank");
      check(64'({alarmFlag, sdaOeN, sdaOut}), 64'h2, "reset pins");
      for (int i = 0; i < 8; i++) begin
         rdChk(wOfs[i], 8'h00);
      end
      // program every byte, bank shows high byte as upper half
      for (int i = 0; i < 8; i++) begin
         u_host.writeReg(optical_alarm_pkg::DEV_ADDR, wOfs[i], wVal[i], ok);
         check(64'(ok), 64'h1, "write ack");
         expBank = {expBank[55:0], wVal[i]};
      end
      check(64'(thresholds), expBank, "bank");
      for (int i = 0; i < 8; i++) begin
         rdChk(wOfs[i], wVal[i]);
      end
      // sequential read: the pointer moves on after each byte, so a host ack gets the next byte
      u_host.start();
      u_host.xfer({optical_alarm_pkg::DEV_ADDR, 1'b0}, 1'b1, rd, k);
      u_host.xfer(optical_alarm_pkg::RX_HIGH_HI_OFS, 1'b1, rd, k);
      u_host.start();
      u_host.xfer({optical_alarm_pkg::DEV_ADDR, 1'b1}, 1'b1, rd, k);
      u_host.xfer(8'hFF, 1'b0, rd, k);
      check(64'(rd), 64'(wVal[4]), "seq byte 0");
      u_host.xfer(8'hFF, 1'b1, rd, k);
      check(64'(rd), 64'(wVal[5]), "seq byte 1");
      u_host.stop();
      // another device address is ignored
      u_host.writeReg(7'h52, 8'h18, 8'h11, ok);
      check(64'(ok), 64'h0, "foreign ack");
      check(64'(thresholds), expBank, "bank kept");
      for (int i = 0; i < 7; i++) begin
         measure(rows[i].tx, rows[i].rx);
         check(64'(alarmFlag), 64'(rows[i].exp), "flags");
      end
      // new values without a measurement strobe leave flags alone
      @(posedge clk);
      txMeas <= 8'hFF;
      rxMeas <= 8'h00;
      repeat (3) @(posedge clk);
      #1;
      check(64'(alarmFlag), 64'(rows[6].exp), "held flags");
      rdChk(optical_alarm_pkg::ALARM_FLAGS_OFS, {rows[6].exp, 4'h0});
      // status bytes keep the last strobed measurement, not the live inputs
      rdChk(optical_alarm_pkg::TX_MEAS_HI_OFS, rows[6].tx);
      rdChk(optical_alarm_pkg::RX_MEAS_HI_OFS, rows[6].rx);
      rdChk(8'h24, optical_alarm_pkg::UNMAPPED_READ);
      // host clears the low bytes as recommended
      for (int i = 1; i < 8; i += 2) begin
         u_host.writeReg(optical_alarm_pkg::DEV_ADDR, wOfs[i], 8'h00, ok);
      end
      check(64'(thresholds), expBank & 64'hFF00_FF00_FF00_FF00, "low bytes cleared");
      measure(8'h3F, 8'h2F);
      check(64'(alarmFlag), 64'h5, "flags after clear");
      // reset in mid-run clears everything at once
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check(64'(thresholds), 64'h0, "mid reset bank");
      check(64'(alarmFlag), 64'h0, "mid reset flags");
      @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      rdChk(8'h20, 8'h00);
      summarize();
   end
endmodule
`default_nettype wire
